// [design/hmw_pkg.sv]
package hmw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_RES_X  = 8'h0C;
  localparam logic [7:0] OFF_TEMP   = 8'h18;
  localparam logic [7:0] OFF_STATE  = 8'h1C;
  localparam logic [7:0] OFF_THR    = 8'h20;

  // Control fields
  localparam int CTL_TEMP_EN = 0;
  localparam int CTL_COLL_EN = 1;
  localparam int CTL_WAKE_EN = 2;
  localparam int CTL_CONT    = 3;
  localparam logic [3:0] CTRL_RST = 4'h3;

  // Status and mask fields
  localparam int ST_DONE  = 0;
  localparam int ST_WAKE  = 1;
  localparam int ST_ABORT = 2;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Converter channel codes
  localparam logic [1:0] CH_X = 2'h0;
  localparam logic [1:0] CH_Y = 2'h1;
  localparam logic [1:0] CH_Z = 2'h2;
  localparam logic [1:0] CH_T = 2'h3;

  // Timing
  localparam int CLK_NS    = 8;
  localparam int T_BIAS_NS = 1000;
  localparam int T_OSC_NS  = 500;
  localparam int T_HALL_NS = 2000;
  localparam int T_INT_NS  = 1000;
  localparam int T_BUSQ_NS = 400;
  localparam int BIAS_CYC  = (T_BIAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_CYC   = (T_OSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALL_CYC  = (T_HALL_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_CYC   = (T_INT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSQ_CYC  = (T_BUSQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int GUARD_CYC = 4;

  typedef enum logic [8:0] {
    S_HALT  = 9'h001,
    S_START = 9'h002,
    S_IDLE  = 9'h004,
    S_BIAS  = 9'h008,
    S_CHECK = 9'h010,
    S_OSC   = 9'h020,
    S_HALL  = 9'h040,
    S_CONV  = 9'h080,
    S_DONE  = 9'h100
  } hmw_state_t;

endpackage : hmw_pkg

// [design/hmw_sequencer.sv]
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module hmw_sequencer
  import hmw_pkg::*;
#(
  parameter int RES_W  = 12,
  parameter int TEMP_W = 10
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic                   irq,
  // Supply monitor, asynchronous
  input  wire logic              supply_ok,
  // Analog front end
  output logic                   bias_en,
  output logic                   osc_en,
  output logic                   hall_bias_en,
  output logic                   adc_start,
  output logic      [1:0]        adc_chan,
  input  wire logic              adc_done,
  input  wire logic [RES_W-1:0]  adc_data,
  // Shared clock and interrupt pin
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe
);

  hmw_state_t         state;
  hmw_state_t         next_state;
  logic               supply_ff1;
  logic               supply_s;
  logic               scl_ff1;
  logic               scl_s;
  logic               scl_d;
  logic [7:0]         tmr;
  logic [7:0]         busq_cnt;
  logic [7:0]         int_cnt;
  logic [2:0]         guard;
  logic               bus_busy;
  logic [1:0]         ch;
  logic               last_ch;
  logic               pend;
  logic               enter_bias;
  logic               in_cycle;
  logic               abort;
  logic               cfg_wr;
  logic               int_fire;
  logic [3:0]         ctrl;
  logic [3:0]         ctrl_act;
  logic [2:0]         status;
  logic [2:0]         mask;
  logic [2:0]         events;
  logic [RES_W-1:0]   res [3];
  logic [TEMP_W-1:0]  temp;
  logic [RES_W-1:0]   thr_lo [3];
  logic [RES_W-1:0]   thr_hi [3];
  logic [RES_W-1:0]   lo_act [3];
  logic [RES_W-1:0]   hi_act [3];
  logic [2:0]         out_ax;
  logic               out_any;
  logic [31:0]        thr_rd;
  logic               thr_hit;

  // Threshold word address: lower at even slots, upper at odd
  function automatic logic [7:0] thr_off(input int axis, input logic upper);
    thr_off = OFF_THR + 8'((axis * 2 + (upper ? 1 : 0)) * 4);
  endfunction : thr_off

  function automatic logic [7:0] res_off(input int axis);
    res_off = OFF_RES_X + 8'(axis * 4);
  endfunction : res_off

  // Two-stage synchronisers; pin levels are unrelated to clk
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      supply_ff1 <= 1'b0;
      supply_s   <= 1'b0;
      scl_ff1    <= 1'b1;
      scl_s      <= 1'b1;
      scl_d      <= 1'b1;
    end
    else
    begin
      supply_ff1 <= supply_ok;
      supply_s   <= supply_ff1;
      scl_ff1    <= scl_i;
      scl_s      <= scl_ff1;
      scl_d      <= scl_s;
    end
  end

  // Bus activity: recent edge on the clock pin. Our own pulse and the
  // synchroniser delay after it are blanked so we never see ourselves.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      busq_cnt <= 8'h00;
    else if ((scl_s ^ scl_d) && !scl_oe && guard == 3'h0)
      busq_cnt <= 8'(BUSQ_CYC);
    else if (busq_cnt != 8'h00)
      busq_cnt <= busq_cnt - 8'h01;
  end
  assign bus_busy = (busq_cnt != 8'h00);

  // Writes that count as reconfiguration and therefore start a cycle
  always_comb
  begin
    thr_hit = 1'b0;
    thr_rd  = 32'h0000_0000;
    for (int i = 0; i < 3; i++)
    begin
      if (reg_addr == thr_off(i, 1'b0))
      begin
        thr_hit = 1'b1;
        thr_rd  = 32'(thr_lo[i]);
      end
      if (reg_addr == thr_off(i, 1'b1))
      begin
        thr_hit = 1'b1;
        thr_rd  = 32'(thr_hi[i]);
      end
    end
  end
  assign cfg_wr = reg_wr && (reg_addr == OFF_CTRL || thr_hit);

  // Control and threshold shadows
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
      for (int i = 0; i < 3; i++)
      begin
        thr_lo[i] <= {1'b1, {(RES_W-1){1'b0}}};
        thr_hi[i] <= {1'b0, {(RES_W-1){1'b1}}};
      end
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFF_CTRL)
        ctrl <= reg_wdata[3:0];
      else if (reg_addr == OFF_MASK)
        mask <= reg_wdata[2:0];
      for (int i = 0; i < 3; i++)
      begin
        if (reg_addr == thr_off(i, 1'b0))
          thr_lo[i] <= reg_wdata[RES_W-1:0];
        if (reg_addr == thr_off(i, 1'b1))
          thr_hi[i] <= reg_wdata[RES_W-1:0];
      end
    end
  end

  // Active copies are frozen for a whole cycle, so a write mid-cycle
  // cannot split one cycle's comparisons across two settings
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctrl_act <= CTRL_RST;
      for (int i = 0; i < 3; i++)
      begin
        lo_act[i] <= {1'b1, {(RES_W-1){1'b0}}};
        hi_act[i] <= {1'b0, {(RES_W-1){1'b1}}};
      end
    end
    else if (enter_bias)
    begin
      ctrl_act <= ctrl;
      for (int i = 0; i < 3; i++)
      begin
        lo_act[i] <= thr_lo[i];
        hi_act[i] <= thr_hi[i];
      end
    end
  end

  // Sequencer
  assign last_ch  = ctrl_act[CTL_TEMP_EN] ? (ch == CH_T) : (ch == CH_Z);
  assign in_cycle = (state == S_BIAS) || (state == S_CHECK) || (state == S_OSC)
                 || (state == S_HALL) || (state == S_CONV) || (state == S_DONE);
  assign abort    = !supply_s && in_cycle;

  always_comb
  begin
    next_state = state;
    if (!supply_s)
      next_state = S_HALT;
    else
    begin
      case (state)
        S_HALT:  next_state = S_START;
        S_START: if (tmr == 8'h00) next_state = pend ? S_BIAS : S_IDLE;
        S_IDLE:  if (pend) next_state = S_BIAS;
        S_BIAS:  if (tmr == 8'h00) next_state = S_CHECK;
        S_CHECK: next_state = S_OSC;
        S_OSC:   if (tmr == 8'h00) next_state = S_HALL;
        S_HALL:  if (tmr == 8'h00) next_state = S_CONV;
        S_CONV:  if (adc_done && last_ch) next_state = S_DONE;
        S_DONE:  next_state = S_IDLE;
        default: next_state = S_HALT;
      endcase
    end
  end
  assign enter_bias = (next_state == S_BIAS) && (state != S_BIAS);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state <= S_HALT;
    else
      state <= next_state;
  end

  // Wait timer, loaded on entry to each timed state
  always_ff @(posedge clk)
  begin
    if (!resetn)
      tmr <= 8'h00;
    else if (next_state != state)
    begin
      case (next_state)
        S_START: tmr <= 8'(BIAS_CYC);
        S_BIAS:  tmr <= 8'(BIAS_CYC);
        S_OSC:   tmr <= 8'(OSC_CYC);
        S_HALL:  tmr <= 8'(HALL_CYC);
        default: tmr <= 8'h00;
      endcase
    end
    else if (tmr != 8'h00)
      tmr <= tmr - 8'h01;
  end

  // Pending cycle request; a new request wins over consumption
  always_ff @(posedge clk)
  begin
    if (!resetn)
      pend <= 1'b0;
    else
      pend <= cfg_wr || abort || (state == S_DONE && ctrl_act[CTL_CONT])
           || (pend && !enter_bias);
  end

  // Analog enables follow the phase of the cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bias_en      <= 1'b0;
      osc_en       <= 1'b0;
      hall_bias_en <= 1'b0;
    end
    else
    begin
      bias_en      <= (next_state == S_START) || (next_state == S_BIAS)
                   || (next_state == S_CHECK) || (next_state == S_OSC)
                   || (next_state == S_HALL) || (next_state == S_CONV);
      osc_en       <= (next_state == S_START) || (next_state == S_OSC)
                   || (next_state == S_HALL) || (next_state == S_CONV);
      hall_bias_en <= (next_state == S_HALL) || (next_state == S_CONV);
    end
  end

  // Channel walk through the one shared converter
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ch        <= CH_X;
      adc_start <= 1'b0;
    end
    else
    begin
      adc_start <= 1'b0;
      if (next_state == S_CONV && state != S_CONV)
      begin
        ch        <= CH_X;
        adc_start <= 1'b1;
      end
      else if (state == S_CONV && next_state == S_CONV && adc_done)
      begin
        ch        <= ch + 2'h1;
        adc_start <= 1'b1;
      end
    end
  end
  assign adc_chan = ch;

  // Results
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 3; i++)
        res[i] <= '0;
      temp <= '0;
    end
    else if (state == S_CONV && adc_done)
    begin
      if (ch == CH_T)
        temp <= adc_data[TEMP_W-1:0];
      else
        res[ch] <= adc_data;
    end
  end

  // Window compare, two's complement
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      out_ax[i] = ($signed(res[i]) > $signed(hi_act[i]))
               || ($signed(res[i]) < $signed(lo_act[i]));
  end
  assign out_any = |out_ax;

  // Pulse is dropped, not delayed, under bus activity: a late pulse
  // would report a stale cycle
  assign int_fire = (state == S_DONE)
                 && (!ctrl_act[CTL_WAKE_EN] || out_any)
                 && !(ctrl_act[CTL_COLL_EN] && bus_busy);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      int_cnt <= 8'h00;
      scl_oe  <= 1'b0;
      guard   <= 3'h0;
    end
    else
    begin
      if (int_fire)
        int_cnt <= 8'(INT_CYC);
      else if (int_cnt != 8'h00)
        int_cnt <= int_cnt - 8'h01;
      scl_oe <= int_fire || (int_cnt > 8'h01);
      if (scl_oe)
        guard <= 3'(GUARD_CYC);
      else if (guard != 3'h0)
        guard <= guard - 3'h1;
    end
  end
  assign scl_o = 1'b0;

  // Sticky status, cleared by read; a same-cycle event survives the clear
  assign events = {abort, (state == S_DONE) && out_any, state == S_DONE};

  always_ff @(posedge clk)
  begin
    if (!resetn)
      status <= 3'h0;
    else if (reg_rd && reg_addr == OFF_STATUS)
      status <= events;
    else
      status <= status | events;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |((status | events) & mask);
  end

  // Read port: answers only, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      if (reg_addr == OFF_CTRL)
        reg_rdata <= 32'(ctrl);
      else if (reg_addr == OFF_STATUS)
        reg_rdata <= 32'(status);
      else if (reg_addr == OFF_MASK)
        reg_rdata <= 32'(mask);
      else if (reg_addr == res_off(0))
        reg_rdata <= 32'(res[0]);
      else if (reg_addr == res_off(1))
        reg_rdata <= 32'(res[1]);
      else if (reg_addr == res_off(2))
        reg_rdata <= 32'(res[2]);
      else if (reg_addr == OFF_TEMP)
        reg_rdata <= 32'(temp);
      else if (reg_addr == OFF_STATE)
        reg_rdata <= {22'h00_0000, pend, state};
      else
        reg_rdata <= thr_rd;
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  halt_on_low_a: assert property (!supply_s |=> state == S_HALT)
    else $error("sequencer not halted on low supply");
  abort_rerun_a: assert property (abort |=> status[ST_ABORT] && pend)
    else $error("mid-cycle restart not recorded");
  axis_order_a: assert property ((state == S_CONV && adc_done && ch == CH_X && supply_s)
      |=> adc_start && adc_chan == CH_Y)
    else $error("Y not converted after X");
  temp_skip_a: assert property ((state == S_CONV && adc_done && ch == CH_Z
      && !ctrl_act[CTL_TEMP_EN] && supply_s) |=> state == S_DONE)
    else $error("temperature not skipped");
  result_store_a: assert property ((state == S_CONV && adc_done && ch == CH_Y)
      |=> res[1] == $past(adc_data))
    else $error("Y result not stored");
  no_wake_in_a: assert property ((state == S_DONE && ctrl_act[CTL_WAKE_EN] && !out_any)
      |=> !scl_oe)
    else $error("wake pulse inside window");
  wake_pulse_a: assert property ((state == S_DONE && out_any && !bus_busy)
      |=> scl_oe [*8])
    else $error("wake pulse missing or short");
  coll_quiet_a: assert property ((ctrl_act[CTL_COLL_EN] && bus_busy) |-> !int_fire)
    else $error("pulse during bus activity");
  open_drain_a: assert property (scl_oe |-> !scl_o)
    else $error("pin driven high");
  cfg_start_a: assert property ((cfg_wr && state == S_IDLE && supply_s
      && $past(supply_s)) |=> ##1 state == S_BIAS || !supply_s)
    else $error("write did not start a cycle");
  cfg_latch_a: assert property ($rose(state == S_BIAS) |-> ctrl_act == $past(ctrl))
    else $error("configuration not latched");
  startup_a: assert property ($fell(state == S_START) && supply_s
      |-> state == S_IDLE || state == S_BIAS)
    else $error("start-up did not reach low power");

  cyc_done_c: cover property (state == S_DONE ##1 state == S_IDLE);
  wake_c: cover property (int_fire && ctrl_act[CTL_WAKE_EN]);
  // Recovery passes a full start-up first, so the rerun comes late
  abort_c: cover property (abort ##[1:1000] state == S_BIAS);
  coll_c: cover property (state == S_DONE && bus_busy && ctrl_act[CTL_COLL_EN]);

endmodule : hmw_sequencer

// [testbench/hmw_adc_model.sv]
`timescale 1ns/1ps
module hmw_adc_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Conversion request
  input  wire logic        adc_start,
  input  wire logic [1:0]  adc_chan,
  input  wire logic        slow,
  input  wire logic [47:0] vals,
  // Conversion answer
  output logic             adc_done,
  output logic [11:0]      adc_data
);
  int          wait_cnt;
  logic [11:0] held;

  // Data only valid with done; inverse otherwise so stale reads show up
  always_ff @(posedge clk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~held;
    if (!resetn)
    begin
      wait_cnt <= 0;
      held     <= 12'h000;
    end
    else if (adc_start)
    begin
      wait_cnt <= slow ? 40 : 3;
      held     <= vals[adc_chan*12 +: 12];
    end
    else if (wait_cnt == 1)
    begin
      wait_cnt <= 0;
      adc_done <= 1'b1;
      adc_data <= held;
    end
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt - 1;
  end
endmodule : hmw_adc_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import hmw_pkg::*;
  logic        clk       = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        supply_ok = 1'b1;
  logic        host_scl  = 1'b1;
  logic        frame     = 1'b0;
  logic        slow      = 1'b0;
  logic [11:0] v [4]     = '{12'h123, 12'h456, 12'h789, 12'hABC};
  logic [1:0]  chans [8];
  logic [31:0] reg_rdata;
  logic [31:0] tmp;
  logic [11:0] adc_data;
  logic [1:0]  adc_chan;
  logic        irq, bias_en, osc_en, hall_bias_en, adc_start, adc_done;
  logic        scl_i, scl_o, scl_oe;
  int          fails, comparisons, nconv, ndone, pulses, plen, last_len, p0, cyc;

  always #4 clk = ~clk;
  // Link clock runs only inside bus frames
  always #40 if (frame) host_scl = ~host_scl;
  // Pull-up wire: low if either side pulls it
  assign scl_i = host_scl & ~scl_oe;

  hmw_sequencer uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .supply_ok(supply_ok), .bias_en(bias_en), .osc_en(osc_en),
    .hall_bias_en(hall_bias_en), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe));

  hmw_adc_model adc (.clk(clk), .resetn(resetn), .adc_start(adc_start),
    .adc_chan(adc_chan), .slow(slow), .vals({v[3], v[2], v[1], v[0]}),
    .adc_done(adc_done), .adc_data(adc_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // Monitors: channel order, front-end state, pulse length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      close_out();
    end
    if (adc_start && nconv < 8)
    begin
      chans[nconv] = adc_chan;
      nconv++;
      chk({bias_en, osc_en, hall_bias_en}, 3'h7);
    end
    if (adc_done)
      ndone++;
    if (scl_oe)
    begin
      plen++;
      chk(scl_o, 1'b0);
    end
    else if (plen != 0)
    begin
      last_len = plen;
      pulses++;
      plen = 0;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic kick(input logic [3:0] ctrl, input logic busy);
    nconv = 0;
    ndone = 0;
    p0    = pulses;
    frame = busy;
    wr(OFF_CTRL, {28'h000_0000, ctrl});
  endtask : kick

  // Waits out the cycle, then judges conversions, pulse, irq and status
  task automatic fin(input int n, input int np, input logic [2:0] st);
    int k;
    k = 0;
    while (ndone < n && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (10) @(posedge clk);
    frame    = 1'b0;
    host_scl = 1'b1;
    repeat (200) @(posedge clk);
    chk(nconv, n);
    for (int i = 0; i < n; i++)
      chk(chans[i], i);
    chk(pulses - p0, np);
    if (np != 0)
      chk(last_len, INT_CYC);
    chk(irq, st[0]);
    rd_chk(OFF_STATUS, {29'h0000_0000, st});
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask : fin

  // The six threshold writes start two cycles; let them drain first
  task automatic settle();
    repeat (1300) @(posedge clk);
    rd(OFF_STATUS, tmp);
  endtask : settle

  task automatic t_reset();
    rd_chk(OFF_CTRL, 32'h0000_0003);
    rd_chk(OFF_MASK, 32'h0000_0000);
    rd_chk(OFF_THR, 32'h0000_0800);
    rd_chk(OFF_THR + 8'h14, 32'h0000_07FF);
    rd_chk(OFF_STATE, 32'h0000_0004);
    rd_chk(8'h40, 32'h0000_0000);
    chk({bias_en, osc_en, scl_oe, irq}, 4'h0);
  endtask : t_reset

  task automatic t_cycle();
    wr(OFF_MASK, 32'h0000_0001);
    rd_chk(OFF_MASK, 32'h0000_0001);
    kick(4'h3, 1'b0);
    fin(4, 1, 3'h1);
    rd_chk(OFF_RES_X, 32'h0000_0123);
    rd_chk(OFF_RES_X + 8'h04, 32'h0000_0456);
    rd_chk(OFF_TEMP, 32'h0000_02BC);
    kick(4'h2, 1'b0);
    fin(3, 1, 3'h1);
  endtask : t_cycle

  task automatic t_wake();
    for (int a = 0; a < 3; a++)
    begin
      v[a] = 12'h010;
      wr(OFF_THR + 8'(8 * a), 32'h0000_0F00 + a);
      wr(OFF_THR + 8'(8 * a + 4), 32'h0000_0100 + a);
    end
    settle();
    kick(4'h6, 1'b0);
    fin(3, 0, 3'h1);
    for (int a = 0; a < 3; a++)
      for (int b = 0; b < 2; b++)
      begin
        v[a] = b ? 12'hE00 : 12'h200;
        kick(4'h6, 1'b0);
        fin(3, 1, 3'h3);
        v[a] = 12'h010;
      end
  endtask : t_wake

  // Slow converter keeps bus edges close to the end of the cycle
  task automatic t_coll();
    v[0] = 12'h200;
    slow = 1'b1;
    kick(4'h6, 1'b1);
    fin(3, 0, 3'h3);
    kick(4'h4, 1'b1);
    fin(3, 1, 3'h3);
    slow = 1'b0;
    v[0] = 12'h010;
  endtask : t_coll

  task automatic t_supply();
    int k;
    kick(4'h3, 1'b0);
    k = 0;
    while (!hall_bias_en && k < 1000)
    begin
      @(posedge clk);
      k++;
    end
    supply_ok <= 1'b0;
    repeat (20) @(posedge clk);
    chk({bias_en, osc_en, hall_bias_en, adc_start}, 4'h0);
    rd_chk(OFF_STATE, 32'h0000_0201);
    repeat (300) @(posedge clk);
    chk(nconv, 0);
    supply_ok <= 1'b1;
    fin(4, 1, 3'h5);
  endtask : t_supply

  // Continuous mode keeps rerunning; the write that clears it lands after
  // the second cycle has latched, so exactly three cycles run
  task automatic t_cont();
    int k;
    kick(4'hA, 1'b0);
    k = 0;
    while (ndone < 3 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    wr(OFF_CTRL, 32'h0000_0002);
    k = 0;
    while (ndone < 9 && k < 6000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (600) @(posedge clk);
    chk(ndone, 9);
    chk(nconv, 8);
    for (int i = 0; i < 8; i++)
      chk(chans[i], i % 3);
    chk(pulses - p0, 3);
    rd_chk(OFF_STATUS, 32'h0000_0001);
  endtask : t_cont

  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (200) @(posedge clk);
    t_reset();
    t_cycle();
    t_wake();
    t_coll();
    t_supply();
    t_cont();
    close_out();
  end
endmodule : tb_top
